// File: rtl/gkd_top.v
// ground key detector for one line channel with register port and interrupt
`include "gkd_consts.vh"

// Notes on behaviour
// - in tip-open, a rising loop closure flag moves linefeed to forward-active
// - ground key pending flag in interrupt vector two, set on valid event
// - enable bit in interrupt enable two gates pending onto the interrupt
// - debounced ground key result readable as status bit
// - read-only 3-bit shadow of the current linefeed state
// - debounce interval is 16 bits in 1.25 ms steps
// - assert and release thresholds are 16 bits, 3.097 uA per lsb
// - a threshold above 16 mA disables detection entirely
// - filter coefficient uses bits 15:3, range zero to 4000h
// - debounced output flips only after input held opposite whole interval
// - assert against high threshold, release against low threshold
// - longitudinal current only produced in tip-open or ring-open
// - coefficient zero blocks signal, 4000h passes it unfiltered
module gkd_top #(
   parameter STEP_CYCLES = `GKD_STEP_CYCLES,  // clocks per sample period
   parameter W           = 16                 // data width
) (
   input  wire         clk_in,          // 250 MHz system clock
   input  wire         sys_rst_in,      // synchronous reset, active high
   input  wire [7:0]   addr_in,         // register byte address
   input  wire [W-1:0] wdata_in,        // register write data
   input  wire         wr_in,           // write strobe
   input  wire         rd_in,           // read strobe
   output reg  [W-1:0] rdata_out,       // read data, cycle after rd_in
   input  wire [W-1:0] long_sample_in,  // signed longitudinal current sample
   input  wire         loop_closure_in, // loop closure flag, same clock
   output reg  [2:0]   linefeed_out,    // current linefeed state
   output reg          ground_key_out,  // debounced ground key result
   output reg          irq_out          // level interrupt, active high
);

   // software registers
   reg  [W-1:0] dbi_ff;
   reg  [W-1:0] hith_ff;
   reg  [W-1:0] loth_ff;
   reg  [W-1:0] lpf_ff;
   reg  [2:0]   linefeed_ff;
   reg          pend_ff;
   reg          irq_en_ff;

   // datapath state
   reg  [W-1:0] sense_ff;
   reg  [W-1:0] filt_ff;
   reg          raw_ff;
   reg          loop_prev_ff;
   reg  [31:0]  tick_cnt_ff;
   reg          tick_ff;

   wire         gk_state;
   wire         gk_rise;

   // decode helpers
   wire         wr_dbi;
   wire         wr_hith;
   wire         wr_loth;
   wire         wr_lpf;
   wire         wr_lf;
   wire         wr_vec;
   wire         wr_en;

   // absolute value of a signed current word
   function [W-1:0] gkd_abs;
      input [W-1:0] v;
      begin
         if (v[W-1])
            gkd_abs = (~v) + {{(W-1){1'b0}}, 1'b1};
         else
            gkd_abs = v;
      end
   endfunction

   // a threshold beyond 16 mA makes the comparator inert
   function gkd_thresh_ok;
      input [W-1:0] t;
      begin
         gkd_thresh_ok = (t <= `GKD_THRESH_MAX);
      end
   endfunction

   assign wr_dbi  = wr_in && (addr_in == `GKD_OFS_DBI);
   assign wr_hith = wr_in && (addr_in == `GKD_OFS_HITH);
   assign wr_loth = wr_in && (addr_in == `GKD_OFS_LOTH);
   assign wr_lpf  = wr_in && (addr_in == `GKD_OFS_LPF);
   assign wr_lf   = wr_in && (addr_in == `GKD_OFS_LINEFEED);
   assign wr_vec  = wr_in && (addr_in == `GKD_OFS_IRQVEC);
   assign wr_en   = wr_in && (addr_in == `GKD_OFS_IRQEN);

   // sample period timer; long count is a parameter so benches can shrink it
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         tick_cnt_ff <= 32'h0000_0000;
         tick_ff     <= 1'b0;
      end else if (tick_cnt_ff >= STEP_CYCLES - 1) begin
         tick_cnt_ff <= 32'h0000_0000;
         tick_ff     <= 1'b1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
         tick_ff     <= 1'b0;
      end
   end

   // longitudinal current exists only while a lead is open
   wire lead_open = (linefeed_ff == `GKD_LF_TIP_OPEN) ||
                    (linefeed_ff == `GKD_LF_RING_OPEN);

   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         sense_ff <= {W{1'b0}};
      end else if (tick_ff) begin
         // zero otherwise, so stale current cannot keep a key asserted
         sense_ff <= lead_open ? long_sample_in : {W{1'b0}};
      end
   end

   // first order low-pass: y += (x - y) * c / 2^14, c clamped to 4000h
   wire [W-1:0]        coef_m = lpf_ff & `GKD_LPF_MASK;
   wire [W-1:0]        coef   = (coef_m > `GKD_LPF_UNITY) ? `GKD_LPF_UNITY : coef_m;
   wire signed [W:0]   diff   = $signed({sense_ff[W-1], sense_ff}) -
                                $signed({filt_ff[W-1], filt_ff});
   // full 34-bit product so nothing is dropped before the shift
   wire signed [2*W+1:0] prod = diff * $signed({1'b0, coef});
   wire signed [W:0]   step   = prod[W+`GKD_LPF_SHIFT:`GKD_LPF_SHIFT];
   wire signed [W:0]   nxt_filt = $signed({filt_ff[W-1], filt_ff}) + step;

   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         filt_ff <= {W{1'b0}};
      end else if (tick_ff) begin
         // zero holds output at rest, 4000h copies the input
         filt_ff <= nxt_filt[W-1:0];
      end
   end

   // hysteresis comparator on the filtered magnitude
   wire [W-1:0] mag     = gkd_abs(filt_ff);
   wire         cmp_on  = gkd_thresh_ok(hith_ff) && gkd_thresh_ok(loth_ff);
   reg          nxt_raw;

   always @* begin
      if (!cmp_on)
         nxt_raw = 1'b0;
      else if (!raw_ff)
         nxt_raw = (mag > hith_ff);
      else
         nxt_raw = !(mag < loth_ff);
   end

   always @(posedge clk_in) begin
      if (sys_rst_in)
         raw_ff <= 1'b0;
      else if (tick_ff)
         raw_ff <= nxt_raw;
   end

   // debounce runs on the same sample period as the filter
   gkd_debounce #(
      .W (W)
   ) u_deb (
      .clk_in      (clk_in),
      .sys_rst_in  (sys_rst_in),
      .tick_in     (tick_ff),
      .raw_in      (raw_ff),
      .interval_in (dbi_ff),
      .state_ff    (gk_state),
      .rise_ff     (gk_rise)
   );

   // configuration registers
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         dbi_ff    <= `GKD_RST_DBI;
         hith_ff   <= `GKD_RST_HITH;
         loth_ff   <= `GKD_RST_LOTH;
         lpf_ff    <= `GKD_RST_LPF;
         irq_en_ff <= 1'b0;
      end else begin
         if (wr_dbi)
            dbi_ff <= wdata_in;
         if (wr_hith)
            hith_ff <= wdata_in;
         if (wr_loth)
            loth_ff <= wdata_in;
         if (wr_lpf)
            lpf_ff <= wdata_in;
         if (wr_en)
            irq_en_ff <= wdata_in[`GKD_GK_IRQ_BIT];
      end
   end

   // linefeed state: host writes it, loop closure in tip-open moves it on.
   // a host write in the same cycle wins, software keeps the last word.
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         linefeed_ff  <= `GKD_RST_LINEFEED;
         loop_prev_ff <= 1'b0;
      end else begin
         loop_prev_ff <= loop_closure_in;
         if (wr_lf)
            linefeed_ff <= wdata_in[`GKD_LF_CTRL_LSB+2:`GKD_LF_CTRL_LSB];
         else if ((linefeed_ff == `GKD_LF_TIP_OPEN) && loop_closure_in && !loop_prev_ff)
            linefeed_ff <= `GKD_LF_FORWARD_ACTIVE_STATE;
      end
   end

   // pending flag: write one to clear, a new event in that cycle wins
   always @(posedge clk_in) begin
      if (sys_rst_in)
         pend_ff <= 1'b0;
      else if (gk_rise)
         pend_ff <= 1'b1;
      else if (wr_vec && wdata_in[`GKD_GK_IRQ_BIT])
         pend_ff <= 1'b0;
   end

   // read mux; unmapped addresses read zero
   reg [W-1:0] nxt_rdata;

   always @* begin
      nxt_rdata = {W{1'b0}};
      case (addr_in)
         `GKD_OFS_DBI:      nxt_rdata = dbi_ff;
         `GKD_OFS_SENSE:    nxt_rdata = sense_ff;
         `GKD_OFS_HITH:     nxt_rdata = hith_ff;
         `GKD_OFS_LOTH:     nxt_rdata = loth_ff;
         `GKD_OFS_LPF:      nxt_rdata = lpf_ff;
         `GKD_OFS_LINEFEED: begin
            nxt_rdata[`GKD_LF_CTRL_LSB+2:`GKD_LF_CTRL_LSB]     = linefeed_ff;
            nxt_rdata[`GKD_LF_SHADOW_LSB+2:`GKD_LF_SHADOW_LSB] = linefeed_ff;
         end
         `GKD_OFS_IRQVEC:   nxt_rdata[`GKD_GK_IRQ_BIT] = pend_ff;
         `GKD_OFS_IRQEN:    nxt_rdata[`GKD_GK_IRQ_BIT] = irq_en_ff;
         `GKD_OFS_STATUS: begin
            nxt_rdata[`GKD_ST_LOOP_BIT] = loop_closure_in;
            nxt_rdata[`GKD_ST_GK_BIT]   = gk_state;
         end
         default:           nxt_rdata = {W{1'b0}};
      endcase
   end

   // outputs straight from flip-flops; data held only the cycle after rd_in
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         rdata_out      <= {W{1'b0}};
         linefeed_out   <= `GKD_RST_LINEFEED;
         ground_key_out <= 1'b0;
         irq_out        <= 1'b0;
      end else begin
         rdata_out      <= rd_in ? nxt_rdata : {W{1'b0}};
         linefeed_out   <= linefeed_ff;
         ground_key_out <= gk_state;
         irq_out        <= pend_ff && irq_en_ff;
      end
   end

endmodule // gkd_top

// File: rtl/gkd_consts.vh
// constants for the ground key detector: offsets, fields, reset values, timing
`ifndef GKD_CONSTS_VH
`define GKD_CONSTS_VH

// register byte offsets
`define GKD_OFS_DBI        8'h00
`define GKD_OFS_SENSE      8'h04
`define GKD_OFS_HITH       8'h08
`define GKD_OFS_LOTH       8'h0c
`define GKD_OFS_LPF        8'h10
`define GKD_OFS_LINEFEED   8'h14
`define GKD_OFS_IRQVEC     8'h18
`define GKD_OFS_IRQEN      8'h1c
`define GKD_OFS_STATUS     8'h20

// linefeed register fields
`define GKD_LF_CTRL_LSB    0
`define GKD_LF_SHADOW_LSB  4
// interrupt vector / enable bit of the ground key event
`define GKD_GK_IRQ_BIT     0
// status register bits
`define GKD_ST_LOOP_BIT    0
`define GKD_ST_GK_BIT      1

// linefeed state codes
`define GKD_LF_OPEN        3'h0
`define GKD_LF_FORWARD_ACTIVE_STATE  3'h1
`define GKD_LF_TIP_OPEN    3'h3
`define GKD_LF_RING_OPEN   3'h7

// reset values
`define GKD_RST_DBI        16'h0000
`define GKD_RST_HITH       16'h0000
`define GKD_RST_LOTH       16'h0000
`define GKD_RST_LPF        16'h0a10
`define GKD_RST_LINEFEED   3'h0

// filter coefficient: bits 15:3 used, 4000h passes unfiltered
`define GKD_LPF_MASK       16'hfff8
`define GKD_LPF_UNITY      16'h4000
`define GKD_LPF_SHIFT      14

// thresholds: one lsb is 3.097 uA; above 16 mA (5166 lsb) detection is off
`define GKD_THRESH_MAX     16'h142e

// timing: debounce step and monitor sample period 1.25 ms, clock period 4 ns
`define GKD_STEP_NS        1250000
`define GKD_CLK_PERIOD_NS  4
`define GKD_STEP_CYCLES    (`GKD_STEP_NS / `GKD_CLK_PERIOD_NS)

`endif

// File: rtl/gkd_debounce.v
// debounce stage for the ground key comparator output
module gkd_debounce #(
   parameter W = 16
) (
   input  wire         clk_in,       // system clock
   input  wire         sys_rst_in,   // synchronous reset, active high
   input  wire         tick_in,      // one pulse per sample period
   input  wire         raw_in,       // comparator output
   input  wire [W-1:0] interval_in,  // debounce interval in sample periods
   output reg          state_ff,     // debounced result
   output reg          rise_ff       // pulse when result goes to 1
);

   reg  [W-1:0] cnt_ff;
   wire [W:0]   cnt_inc;

   assign cnt_inc = {1'b0, cnt_ff} + {{W{1'b0}}, 1'b1};

   // count while input disagrees; restart as soon as it agrees again
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         cnt_ff   <= {W{1'b0}};
         state_ff <= 1'b0;
         rise_ff  <= 1'b0;
      end else begin
         rise_ff <= 1'b0;
         if (tick_in) begin
            if (raw_in == state_ff) begin
               cnt_ff <= {W{1'b0}};
            end else if (cnt_inc >= {1'b0, interval_in}) begin
               // held opposite for the whole interval
               state_ff <= raw_in;
               rise_ff  <= raw_in;
               cnt_ff   <= {W{1'b0}};
            end else begin
               cnt_ff <= cnt_inc[W-1:0];
            end
         end
      end
   end

endmodule // gkd_debounce

// File: testbench/gkd_top_sva.sv
// port assertions for the ground key detector
module gkd_top_chk #(
   parameter STEP_CYCLES = 4,
   parameter W           = 16
) (
   input wire logic         clk_in,          // clock
   input wire logic         sys_rst_in,      // reset
   input wire logic [7:0]   addr_in,         // address
   input wire logic [W-1:0] wdata_in,        // write data
   input wire logic         wr_in,           // write strobe
   input wire logic         rd_in,           // read strobe
   input wire logic [W-1:0] rdata_out,       // read data
   input wire logic [W-1:0] long_sample_in,  // sense input
   input wire logic         loop_closure_in, // loop flag
   input wire logic [2:0]   linefeed_out,    // linefeed state
   input wire logic         ground_key_out,  // ground key
   input wire logic         irq_out          // interrupt
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // read data only right after a read
   property p_rd_idle; !$past(rd_in) |-> rdata_out == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   property p_hole; $past(rd_in) && $past(addr_in) > 8'h20 |-> rdata_out == 16'h0000; endproperty
   a_hole: assert property (p_hole) else $error("unmapped read not zero");
   // both linefeed fields track the state output
   property p_lf_rd;
      $past(rd_in) && $past(addr_in) == 8'h14
      |-> rdata_out[6:4] == linefeed_out && rdata_out[2:0] == linefeed_out;
   endproperty
   a_lf_rd: assert property (p_lf_rd) else $error("linefeed read mismatch");
   property p_st_rd; $past(rd_in) && $past(addr_in) == 8'h20 |-> rdata_out[0] == $past(loop_closure_in); endproperty
   a_st_rd: assert property (p_st_rd) else $error("status loop bit wrong");
   // writes excluded: a host write in the same cycle wins
   property p_auto;
      linefeed_out == 3'h3 && $rose(loop_closure_in) && !wr_in && !$past(wr_in)
      |-> ##2 linefeed_out == 3'h1;
   endproperty
   a_auto: assert property (p_auto) else $error("no move to forward active");
   property p_lf_chg; $changed(linefeed_out) |-> $past(wr_in, 2) || $past(loop_closure_in, 2); endproperty
   a_lf_chg: assert property (p_lf_chg) else $error("linefeed moved by itself");
   property p_irq_up; $rose(irq_out) |-> ground_key_out || $past(wr_in) || $past(wr_in, 2); endproperty
   a_irq_up: assert property (p_irq_up) else $error("interrupt without event");
   property p_irq_dn; $fell(irq_out) |-> $past(wr_in) || $past(wr_in, 2); endproperty
   a_irq_dn: assert property (p_irq_dn) else $error("interrupt dropped alone");
   // debounce steps once per sample period, never faster
   property p_gk_hold; $changed(ground_key_out) |=> $stable(ground_key_out)[*3]; endproperty
   a_gk_hold: assert property (p_gk_hold) else $error("ground key toggled fast");
endmodule // gkd_top_chk
bind gkd_top gkd_top_chk #(.STEP_CYCLES(STEP_CYCLES), .W(W)) chk_u (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .long_sample_in(long_sample_in),
   .loop_closure_in(loop_closure_in), .linefeed_out(linefeed_out),
   .ground_key_out(ground_key_out), .irq_out(irq_out));

// File: testbench/gkd_line_model.sv
// subscriber loop model seen through the linefeed
module gkd_line_model (
   input  wire logic       clk_in,                // clock
   input  wire logic [1:0] mode_in,               // 0 open 1 ring gnd 2 weak 3 loop
   output logic      [15:0] long_out = 16'h0000,  // longitudinal sample
   output logic             loop_out = 1'b0       // loop closure flag
);
   timeunit 1ns;
   timeprecision 1ps;
   // -11 ma and -6 ma in 3.097 ua steps; weak sits inside the hysteresis
   always @(posedge clk_in) begin
      case (mode_in)
         2'h1: long_out <= 16'hf220;
         2'h2: long_out <= 16'hf86f;
         default: long_out <= 16'h0000;
      endcase
      loop_out <= mode_in != 2'h0;
   end
endmodule // gkd_line_model

// File: testbench/gkd_top_tb.sv
// bench for the ground key detector
module gkd_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [1:0]  mode = 2'h0;
   logic [15:0] rdata, long_s;
   logic [2:0]  lf;
   logic        lc, gk, irq;
   int          fails = 0;
   int          checks = 0;
   // short sample period keeps debounce runs brief
   gkd_top #(.STEP_CYCLES(4)) dut_u (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .long_sample_in(long_s),
      .loop_closure_in(lc), .linefeed_out(lf), .ground_key_out(gk), .irq_out(irq));
   gkd_line_model line_u (.clk_in(clk_in), .mode_in(mode), .long_out(long_s), .loop_out(lc));
   initial begin
      forever #2 clk_in = ~clk_in;
   end
   task automatic test_done();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] s, e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // strobes drop at the taking edge; the #1 keeps back to back calls apart
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input string n, input logic [7:0] a, input logic [15:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1;
      chk(n, rdata, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wait_gk(input logic v);
      int i;
      for (i = 0; i < 200 && gk !== v; i++) cyc(1);
      if (gk !== v) begin
         fails++;
         test_done();
      end
   endtask
   task automatic t_reset();
      rd_chk("coef", 8'h10, 16'h0a10);
      rd_chk("dbi", 8'h00, 16'h0000);
      rd_chk("hole", 8'h24, 16'h0000);
      wr_reg(8'h00, 16'h0002);
      wr_reg(8'h08, 16'h08d4); // 7 ma
      wr_reg(8'h0c, 16'h064e); // 5 ma
      wr_reg(8'h10, 16'h4000);
      wr_reg(8'h1c, 16'h0001);
      rd_chk("hith", 8'h08, 16'h08d4);
      rd_chk("coef", 8'h10, 16'h4000);
   endtask
   // ring grounded: no sense while open, event in ring open, hysteresis
   task automatic t_key();
      mode <= 2'h1;
      cyc(12);
      rd_chk("sense", 8'h04, 16'h0000);
      wr_reg(8'h14, 16'h0007);
      cyc(8);
      chk("early", {15'h0, gk}, 16'h0000);
      wait_gk(1'b1);
      cyc(2);
      rd_chk("sense", 8'h04, 16'hf220);
      rd_chk("status", 8'h20, 16'h0003);
      rd_chk("vec", 8'h18, 16'h0001);
      chk("irq", {15'h0, irq}, 16'h0001);
      wr_reg(8'h1c, 16'h0000);
      cyc(2);
      chk("masked", {15'h0, irq}, 16'h0000);
      wr_reg(8'h18, 16'h0001);
      wr_reg(8'h1c, 16'h0001);
      cyc(2);
      chk("cleared", {15'h0, irq}, 16'h0000);
      mode <= 2'h2;
      cyc(40);
      chk("held", {15'h0, gk}, 16'h0001);
      mode <= 2'h0;
      wait_gk(1'b0);
   endtask
   task automatic t_off();
      wr_reg(8'h08, 16'h142f);
      mode <= 2'h1;
      cyc(60);
      chk("off", {15'h0, gk}, 16'h0000);
      mode <= 2'h0;
   endtask
   task automatic t_auto();
      wr_reg(8'h14, 16'h0000);
      mode <= 2'h3;
      cyc(4);
      chk("stay", {13'h0, lf}, 16'h0000);
      mode <= 2'h0;
      wr_reg(8'h14, 16'h0003);
      cyc(4);
      mode <= 2'h3;
      cyc(4);
      chk("lf", {13'h0, lf}, 16'h0001);
      rd_chk("lf", 8'h14, 16'h0011);
   endtask
   initial begin
      repeat (16) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      cyc(1);
      t_reset();
      t_key();
      t_off();
      t_auto();
      test_done();
   end
endmodule // gkd_top_tb
